// [core/ewcs_pkg.sv]
// Constants shared by the electrode wear current stepper.
// Assumes a single APB clock domain; offsets are byte addresses.
package ewcs_pkg;
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_STAT    = 8'h04;
  localparam logic [7:0]  OFF_SPOTS   = 8'h08;
  localparam logic [7:0]  OFF_FACT    = 8'h0c;
  localparam logic [7:0]  OFF_SEG0    = 8'h10;
  localparam logic [7:0]  OFF_SEGEND  = 8'h28;
  localparam int          SEG_N       = 7;
  // Control register fields
  localparam int          CTRL_LIM    = 0;
  localparam int          CTRL_PRE    = 4;
  localparam int          CTRL_POST   = 5;
  localparam int          CTRL_SEG    = 6;
  localparam int          CTRL_CLR    = 16;
  localparam int          CTRL_ACK    = 17;
  localparam int          SEG_INC     = 16;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  // Segment ranges
  localparam logic [13:0] SPOTS1_MAX  = 14'h2710;
  localparam logic [13:0] SPOTSN_MAX  = 14'h1388;
  localparam logic [13:0] SPOTSN_MIN  = 14'h0001;
  localparam logic [5:0]  INC_MAX     = 6'h3c;
  localparam logic [6:0]  PCT_FULL    = 7'h64;
  // Scale factor, 16 fraction bits
  localparam int          FRAC_W      = 16;
  localparam logic [23:0] UNITY       = 24'h01_0000;
  localparam int          NUM_W       = 45;
  localparam logic [5:0]  DIV_LAST    = 6'h2c;
  // Scaled channels
  localparam int          CH_CUR      = 0;
  localparam int          CH_CLO      = 1;
  localparam int          CH_CHI      = 2;
  localparam int          CH_ALO      = 3;
  localparam int          CH_AHI      = 4;
  localparam int          CH_PRE      = 5;
  localparam int          CH_POST     = 6;
  localparam int          CH_NRG      = 7;
  localparam int          CH_N        = 8;
  typedef enum logic [1:0] {
    EWCS_IDLE = 2'b00,
    EWCS_DIV  = 2'b01,
    EWCS_DONE = 2'b11
  } ewcs_div_t;
endpackage

// [core/ewcs_stepper.sv]
// Electrode wear current stepper with bad-spot stop, APB register slave.
// Assumes spot reports and measurements synchronous to pclk.
//
// Functional notes
// - Halt after limit consecutive bad spots (0-15)
// - Bad spot: current or angle outside window
// - Limit zero disables the bad-spot stop
// - Pre-weld enable activates pre-weld settings
// - Post-weld enable activates post-weld settings
// - Segment count programmable 0 to 7
// - Segment one 0-10000 spots, others 1-5000
// - Zero count, spots1 or increment1 disables compensation
// - No segments: spots1 is maximum spot count
// - Segment increment 0-60 reached at segment end
// - Current rises gradually spot by spot
// - Increment applies to every program in use
// - Limits, pre/post power, energy scale alike
// - Curve changes apply to subsequent spots
// - Curve complete: stop, end-of-life until cleared
// - Segment increments compound on segment start level
`timescale 1ns/10ps
`default_nettype none
module ewcs_stepper (
  input  wire logic        pclk,              // APB clock, 200 MHz
  input  wire logic        presetn,           // Async reset, active low
  input  wire logic [7:0]  paddr,             // APB address
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB enable
  input  wire logic        pwrite,            // APB write
  input  wire logic [31:0] pwdata,            // APB write data
  output logic      [31:0] prdata,            // APB read data
  output logic             pready,            // APB ready
  output logic             pslverr,           // APB error, unmapped
  input  wire logic        spot_done,         // Spot completed pulse
  input  wire logic [15:0] meas_current,      // Measured current
  input  wire logic [15:0] meas_angle,        // Measured angle
  input  wire logic [15:0] weld_current,      // Base current setting
  input  wire logic [15:0] current_low_limit, // Base current min
  input  wire logic [15:0] current_high_limit,// Base current max
  input  wire logic [15:0] angle_low_limit,   // Base angle min
  input  wire logic [15:0] angle_high_limit,  // Base angle max
  input  wire logic [15:0] pre_weld_power,    // Base pre-weld power
  input  wire logic [15:0] post_weld_power,   // Base post-weld power
  input  wire logic [15:0] energy_target,     // Base energy level
  output logic      [15:0] weld_current_adj,  // Scaled current
  output logic      [15:0] cur_low_adj,       // Scaled current min
  output logic      [15:0] cur_high_adj,      // Scaled current max
  output logic      [15:0] ang_low_adj,       // Scaled angle min
  output logic      [15:0] ang_high_adj,      // Scaled angle max
  output logic      [15:0] pre_power_adj,     // Scaled pre-weld power
  output logic      [15:0] post_power_adj,    // Scaled post-weld power
  output logic      [15:0] energy_adj,        // Scaled energy level
  output logic             pre_weld_active,   // Pre-weld, first_cool_time on
  output logic             post_weld_active,  // current_ramp_down, third_cool_time, post on
  output logic             bad_spot_halt,     // Stop on bad spots
  output logic             end_of_life,       // Electrode life over
  output logic             machine_halt       // Either stop
);
  // Register decode
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= ewcs_pkg::OFF_SEGEND);
  endfunction
  function automatic logic [13:0] clamp_spots(input logic [2:0] i, input logic [13:0] v);
    if (i == 3'h0) begin
      clamp_spots = (v > ewcs_pkg::SPOTS1_MAX) ? ewcs_pkg::SPOTS1_MAX : v;
    end else if (v < ewcs_pkg::SPOTSN_MIN) begin
      clamp_spots = ewcs_pkg::SPOTSN_MIN;
    end else begin
      clamp_spots = (v > ewcs_pkg::SPOTSN_MAX) ? ewcs_pkg::SPOTSN_MAX : v;
    end
  endfunction

  logic [3:0]  lim;
  logic        pre_en;
  logic        post_en;
  logic [2:0]  seg_count;
  logic [13:0] seg_spots [ewcs_pkg::SEG_N];
  logic [5:0]  seg_inc   [ewcs_pkg::SEG_N];
  logic [16:0] total_spots;
  logic [14:0] seg_k;
  logic [2:0]  seg_idx;
  logic [3:0]  bad_cnt;
  logic [23:0] seg_base;
  logic [23:0] factor_live;
  logic [23:0] factor;
  logic [15:0] adj [ewcs_pkg::CH_N];
  ewcs_pkg::ewcs_div_t div_state;
  logic [5:0]  div_cnt;
  logic [44:0] div_num;
  logic [19:0] div_den;
  logic [19:0] div_rem;
  logic [23:0] div_q;
  logic        div_full;
  logic [2:0]  div_idx;
  logic        div_stale;

  wire         acc_wr   = psel && penable && pwrite && mapped(paddr);
  wire         setup    = psel && !penable;
  wire         wr_ctrl  = acc_wr && (paddr == ewcs_pkg::OFF_CTRL);
  wire         clr      = wr_ctrl && pwdata[ewcs_pkg::CTRL_CLR];
  wire         ack      = wr_ctrl && pwdata[ewcs_pkg::CTRL_ACK];
  wire  [7:0]  seg_off  = paddr - ewcs_pkg::OFF_SEG0;
  wire         seg_hit  = (paddr >= ewcs_pkg::OFF_SEG0) && (paddr <= ewcs_pkg::OFF_SEGEND);
  wire  [2:0]  seg_sel  = seg_hit ? seg_off[4:2] : 3'h0;

  // Curve state decode
  wire         comp_off = (seg_count == 3'h0) || (seg_spots[0] == 14'h0)
                          || (seg_inc[0] == 6'h0);
  wire         max_mode = (seg_count == 3'h0) && (seg_spots[0] != 14'h0);
  wire  [13:0] cur_len  = seg_spots[seg_idx];
  wire  [3:0]  idx_p1   = {1'b0, seg_idx} + 4'h1;
  wire         last_seg = idx_p1 >= {1'b0, seg_count};
  wire         spot_take = spot_done && !machine_halt;
  wire  [14:0] k_inc    = spot_take ? seg_k + 15'h1 : seg_k;
  wire  [16:0] tot_inc  = total_spots + 17'h1;
  wire         oob      = (meas_current < adj[ewcs_pkg::CH_CLO])
                          || (meas_current > adj[ewcs_pkg::CH_CHI])
                          || (meas_angle < adj[ewcs_pkg::CH_ALO])
                          || (meas_angle > adj[ewcs_pkg::CH_AHI]);
  wire  [3:0]  bad_p1   = bad_cnt + 4'h1;
  wire         bad_set  = spot_take && oob && (lim != 4'h0) && (bad_p1 == lim);
  wire         eol_set  = spot_take && ((max_mode && tot_inc >= {3'h0, seg_spots[0]})
                          || (!comp_off && last_seg && k_inc >= {1'b0, cur_len}));
  wire         advance  = (div_state == ewcs_pkg::EWCS_DONE) && !div_stale && div_full
                          && (div_idx == seg_idx) && !last_seg
                          && (k_inc >= {1'b0, cur_len});
  wire  [14:0] next_k   = clr ? 15'h0 : (advance ? k_inc - {1'b0, cur_len} : k_inc);

  // Control register and segment table
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lim       <= 4'h0;
      pre_en    <= 1'b0;
      post_en   <= 1'b0;
      seg_count <= 3'h0;
    end else if (wr_ctrl) begin
      lim       <= pwdata[ewcs_pkg::CTRL_LIM +: 4];
      pre_en    <= pwdata[ewcs_pkg::CTRL_PRE];
      post_en   <= pwdata[ewcs_pkg::CTRL_POST];
      seg_count <= pwdata[ewcs_pkg::CTRL_SEG +: 3];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < ewcs_pkg::SEG_N; gi++) begin : g_seg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          seg_spots[gi] <= (gi == 0) ? 14'h0 : ewcs_pkg::SPOTSN_MIN;
          seg_inc[gi]   <= 6'h0;
        end else if (acc_wr && seg_hit && (seg_sel == 3'(gi))) begin
          seg_spots[gi] <= clamp_spots(3'(gi), pwdata[13:0]);
          seg_inc[gi]   <= (pwdata[ewcs_pkg::SEG_INC +: 6] > ewcs_pkg::INC_MAX)
                           ? ewcs_pkg::INC_MAX : pwdata[ewcs_pkg::SEG_INC +: 6];
        end
      end
    end
  endgenerate

  // Spot counting, segment walk and stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      total_spots   <= 17'h0;
      seg_k         <= 15'h0;
      seg_idx       <= 3'h0;
      seg_base      <= ewcs_pkg::UNITY;
      factor_live   <= ewcs_pkg::UNITY;
      bad_cnt       <= 4'h0;
      bad_spot_halt <= 1'b0;
      end_of_life   <= 1'b0;
    end else begin
      seg_k <= next_k;
      if (clr) begin
        total_spots <= 17'h0;
        seg_idx     <= 3'h0;
        seg_base    <= ewcs_pkg::UNITY;
        factor_live <= ewcs_pkg::UNITY;
        end_of_life <= 1'b0;
      end else begin
        if (spot_take) begin
          total_spots <= tot_inc;
        end
        if (eol_set) begin
          end_of_life <= 1'b1;
        end
        if (div_state == ewcs_pkg::EWCS_DONE && !div_stale) begin
          factor_live <= div_q;
        end
        if (advance) begin
          seg_base <= div_q;
          seg_idx  <= seg_idx + 3'h1;
        end
      end
      if (bad_set) begin
        bad_spot_halt <= 1'b1;
      end else if (ack) begin
        bad_spot_halt <= 1'b0;
      end
      if (ack && !bad_set) begin
        bad_cnt <= 4'h0;
      end else if (spot_take) begin
        bad_cnt <= oob ? bad_p1 : 4'h0;
      end
    end
  end

  // Serial divider: base * (100*len + inc*k) / (100*len)
  wire  [14:0] k_clip  = (seg_k > {1'b0, cur_len}) ? {1'b0, cur_len} : seg_k;
  wire  [19:0] den     = 20'(cur_len * ewcs_pkg::PCT_FULL);
  wire  [20:0] mult    = {1'b0, den} + 21'(seg_inc[seg_idx] * k_clip);
  wire  [20:0] rem_sh  = {div_rem, div_num[44]};
  wire         rem_ge  = rem_sh >= {1'b0, div_den};
  wire  [20:0] rem_sub = rem_sh - {1'b0, div_den};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_state <= ewcs_pkg::EWCS_IDLE;
      div_cnt   <= 6'h0;
      div_num   <= 45'h0;
      div_den   <= 20'h1;
      div_rem   <= 20'h0;
      div_q     <= 24'h0;
      div_full  <= 1'b0;
      div_idx   <= 3'h0;
      div_stale <= 1'b0;
    end else begin
      case (div_state)
        ewcs_pkg::EWCS_IDLE: begin
          if (!comp_off && !clr) begin
            div_num   <= 45'(seg_base * mult);
            div_den   <= den;
            div_rem   <= 20'h0;
            div_cnt   <= 6'h0;
            div_full  <= seg_k >= {1'b0, cur_len};
            div_idx   <= seg_idx;
            div_stale <= 1'b0;
            div_state <= ewcs_pkg::EWCS_DIV;
          end
        end
        ewcs_pkg::EWCS_DIV: begin
          div_rem   <= rem_ge ? rem_sub[19:0] : rem_sh[19:0];
          div_q     <= {div_q[22:0], rem_ge};
          div_num   <= {div_num[43:0], 1'b0};
          div_cnt   <= div_cnt + 6'h1;
          div_stale <= div_stale || clr || comp_off;
          if (div_cnt == ewcs_pkg::DIV_LAST) begin
            div_state <= ewcs_pkg::EWCS_DONE;
          end
        end
        ewcs_pkg::EWCS_DONE: begin
          div_state <= ewcs_pkg::EWCS_IDLE;
        end
        default: begin
          div_state <= ewcs_pkg::EWCS_IDLE;
        end
      endcase
    end
  end

  // Scaled settings for every program in use
  wire  [15:0] pre_power_gate  = pre_en ? pre_weld_power : 16'h0;
  wire  [15:0] post_power_gate = post_en ? post_weld_power : 16'h0;
  wire  [15:0] base_in [ewcs_pkg::CH_N];
  assign base_in[ewcs_pkg::CH_CUR]  = weld_current;
  assign base_in[ewcs_pkg::CH_CLO]  = current_low_limit;
  assign base_in[ewcs_pkg::CH_CHI]  = current_high_limit;
  assign base_in[ewcs_pkg::CH_ALO]  = angle_low_limit;
  assign base_in[ewcs_pkg::CH_AHI]  = angle_high_limit;
  assign base_in[ewcs_pkg::CH_PRE]  = pre_power_gate;
  assign base_in[ewcs_pkg::CH_POST] = post_power_gate;
  assign base_in[ewcs_pkg::CH_NRG]  = energy_target;

  generate
    for (gi = 0; gi < ewcs_pkg::CH_N; gi++) begin : g_ch
      wire [39:0] prod = base_in[gi] * factor;
      wire [23:0] shr  = prod[39:ewcs_pkg::FRAC_W];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          adj[gi] <= 16'h0;
        end else begin
          adj[gi] <= (shr[23:16] != 8'h0) ? 16'hffff : shr[15:0];
        end
      end
    end
  endgenerate

  assign weld_current_adj = adj[ewcs_pkg::CH_CUR];
  assign cur_low_adj      = adj[ewcs_pkg::CH_CLO];
  assign cur_high_adj     = adj[ewcs_pkg::CH_CHI];
  assign ang_low_adj      = adj[ewcs_pkg::CH_ALO];
  assign ang_high_adj     = adj[ewcs_pkg::CH_AHI];
  assign pre_power_adj    = adj[ewcs_pkg::CH_PRE];
  assign post_power_adj   = adj[ewcs_pkg::CH_POST];
  assign energy_adj       = adj[ewcs_pkg::CH_NRG];

  // Flag outputs and APB answer
  wire  [31:0] rd_seg  = {10'h0, seg_inc[seg_sel], 2'h0, seg_spots[seg_sel]};
  wire  [31:0] rd_ctrl = {23'h0, seg_count, post_en, pre_en, lim};
  wire  [31:0] rd_stat = {22'h0, seg_idx, bad_cnt, !comp_off, end_of_life, bad_spot_halt};
  wire  [31:0] rd_data = !mapped(paddr) ? 32'h0 :
                         (paddr == ewcs_pkg::OFF_CTRL)  ? rd_ctrl :
                         (paddr == ewcs_pkg::OFF_STAT)  ? rd_stat :
                         (paddr == ewcs_pkg::OFF_SPOTS) ? {15'h0, total_spots} :
                         (paddr == ewcs_pkg::OFF_FACT)  ? {8'h0, factor} : rd_seg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      factor           <= ewcs_pkg::UNITY;
      pre_weld_active  <= 1'b0;
      post_weld_active <= 1'b0;
      machine_halt     <= 1'b0;
      prdata           <= 32'h0;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
    end else begin
      factor           <= comp_off ? ewcs_pkg::UNITY : factor_live;
      pre_weld_active  <= pre_en;
      post_weld_active <= post_en;
      machine_halt     <= (bad_set || (bad_spot_halt && !ack) || eol_set
                           || (end_of_life && !clr));
      pready           <= 1'b1;
      if (setup) begin
        prdata  <= rd_data;
        pslverr <= !mapped(paddr);
      end
    end
  end

  // Checks
  sequence s_last_bad;
    spot_take && oob && (lim != 4'h0) && (bad_p1 == lim);
  endsequence
  sequence s_div_start;
    (div_state == ewcs_pkg::EWCS_IDLE) && !comp_off && !clr;
  endsequence
  sequence s_div_busy;
    (div_state == ewcs_pkg::EWCS_DIV)[*8];
  endsequence
  property p_bad_halt;
    @(posedge pclk) disable iff (!presetn) s_last_bad |=> bad_spot_halt && machine_halt;
  endproperty
  a_bad_halt: assert property (p_bad_halt) else $error("no halt at bad limit");
  property p_bad_count;
    @(posedge pclk) disable iff (!presetn)
      (spot_take && oob && !ack && !bad_set) |=> (bad_cnt == $past(bad_cnt) + 4'h1);
  endproperty
  a_bad_count: assert property (p_bad_count) else $error("bad spot not counted");
  property p_no_stop;
    @(posedge pclk) disable iff (!presetn) (lim == 4'h0 && !bad_spot_halt) |=> !bad_spot_halt;
  endproperty
  a_no_stop: assert property (p_no_stop) else $error("halt with limit zero");
  property p_pre_off;
    @(posedge pclk) disable iff (!presetn) (!pre_en)[*2] |-> (pre_power_adj == 16'h0);
  endproperty
  a_pre_off: assert property (p_pre_off) else $error("pre-weld power while off");
  property p_post_off;
    @(posedge pclk) disable iff (!presetn) (!post_en)[*2] |-> (post_power_adj == 16'h0);
  endproperty
  a_post_off: assert property (p_post_off) else $error("post-weld power while off");
  property p_comp_off;
    @(posedge pclk) disable iff (!presetn) comp_off |=> (factor == ewcs_pkg::UNITY);
  endproperty
  a_comp_off: assert property (p_comp_off) else $error("factor not unity when off");
  property p_eol_hold;
    @(posedge pclk) disable iff (!presetn) (end_of_life && !clr) |=> end_of_life && machine_halt;
  endproperty
  a_eol_hold: assert property (p_eol_hold) else $error("end of life dropped");
  property p_good_clear;
    @(posedge pclk) disable iff (!presetn) (spot_take && !oob) |=> (bad_cnt == 4'h0);
  endproperty
  a_good_clear: assert property (p_good_clear) else $error("good spot kept count");
  property p_div_time;
    @(posedge pclk) disable iff (!presetn)
      s_div_start |-> ##1 s_div_busy ##38 (div_state == ewcs_pkg::EWCS_DONE);
  endproperty
  a_div_time: assert property (p_div_time) else $error("divider time wrong");
endmodule
`default_nettype wire

// [core/ewcs_stepper_unused_placeholder_removed.sv]
// Intentionally empty: no further design logic.
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [verif/ewcs_welder.sv]
// Weld sequencer model: turns a fire request into one spot report.
// Assumes requests from the bench at rising pclk edges.
`timescale 1ns/10ps
`default_nettype none
module ewcs_welder (
  input  wire logic        pclk,         // Clock
  input  wire logic        presetn,      // Reset, active low
  input  wire logic        fire,         // Request one spot
  input  wire logic [15:0] fire_cur,     // Current to report
  input  wire logic [15:0] fire_ang,     // Angle to report
  output logic             spot_done,    // Spot completed pulse
  output logic      [15:0] meas_current, // Measured current
  output logic      [15:0] meas_angle    // Measured angle
);
  // Outside a report the lines toggle, never hold the last value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spot_done    <= 1'b0;
      meas_current <= 16'h0000;
      meas_angle   <= 16'h0000;
    end else begin
      spot_done    <= fire;
      meas_current <= fire ? fire_cur : ~meas_current;
      meas_angle   <= fire ? fire_ang : ~meas_angle;
    end
  end
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Testbench for the wear current stepper: APB tasks and spot reports.
// Assumes the sequencer model beside it; dressing option stays off.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, spot_done, pre_act, post_act;
  logic        bad_halt, eol, halt;
  logic        fire     = 1'b0;
  logic [15:0] fire_cur = 16'h0;
  logic [15:0] fire_ang = 16'h0;
  logic [15:0] meas_current, meas_angle;
  logic [15:0] adj [8];
  logic [15:0] base [8] = '{16'h03e8, 16'h0064, 16'h00c8, 16'h0032,
                            16'h0096, 16'h0190, 16'h012c, 16'h07d0};
  logic [31:0] fac [6] = '{32'h12000, 32'h14000, 32'h16000,
                           32'h18000, 32'h1e000, 32'h24000};
  int          fails = 0;
  int          n_compared = 0;
  int          cycles = 0;
  always #2.5 pclk = ~pclk;
  ewcs_welder i_ewcs_welder (.pclk(pclk), .presetn(presetn), .fire(fire),
    .fire_cur(fire_cur), .fire_ang(fire_ang), .spot_done(spot_done),
    .meas_current(meas_current), .meas_angle(meas_angle));
  ewcs_stepper i_ewcs_stepper (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .spot_done(spot_done),
    .meas_current(meas_current), .meas_angle(meas_angle), .weld_current(base[0]),
    .current_low_limit(base[1]), .current_high_limit(base[2]),
    .angle_low_limit(base[3]), .angle_high_limit(base[4]),
    .pre_weld_power(base[5]), .post_weld_power(base[6]), .energy_target(base[7]),
    .weld_current_adj(adj[0]), .cur_low_adj(adj[1]), .cur_high_adj(adj[2]),
    .ang_low_adj(adj[3]), .ang_high_adj(adj[4]), .pre_power_adj(adj[5]),
    .post_power_adj(adj[6]), .energy_adj(adj[7]), .pre_weld_active(pre_act),
    .post_weld_active(post_act), .bad_spot_halt(bad_halt), .end_of_life(eol),
    .machine_halt(halt));
  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic spot(input logic [15:0] c, input logic [15:0] a);
    @(posedge pclk);
    fire     <= 1'b1;
    fire_cur <= c;
    fire_ang <= a;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  function automatic logic [15:0] sc(input logic [15:0] b);
    sc = 16'((32'(b) * 32'h24000) >> 16);
  endfunction
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(8'h04, 32'h0);
    rdchk(8'h0c, {8'h00, ewcs_pkg::UNITY});
    rdchk(8'h14, 32'h1);
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 8'h02, 32'hffff_ffff);
    chk({31'h0, err}, 32'h1);
    rdchk(8'h00, 32'h0);
    $display("test reset done");
    apb(1'b1, 8'h10, 32'h003f_3fff);
    rdchk(8'h10, 32'h003c_2710);
    apb(1'b1, 8'h14, 32'h0000_0000);
    rdchk(8'h14, 32'h0000_0001);
    apb(1'b1, 8'h18, 32'h0000_1389);
    rdchk(8'h18, 32'h0000_1388);
    apb(1'b1, 8'h00, 32'h0000_01ff);
    rdchk(8'h00, 32'h0000_01ff);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h00, {26'h0, i[1:0], 4'h0});
      repeat (2) @(posedge pclk);
      chk({30'h0, pre_act, post_act}, {30'h0, i[0], i[1]});
      chk({16'h0, adj[5]}, i[0] ? {16'h0, base[5]} : 32'h0);
      chk({16'h0, adj[6]}, i[1] ? {16'h0, base[6]} : 32'h0);
    end
    for (int j = 0; j < 8; j++) base[j] <= base[j] + 16'h0001;
    repeat (3) @(posedge pclk);
    for (int j = 0; j < 8; j++) chk({16'h0, adj[j]}, {16'h0, base[j]});
    $display("test setup done");
    apb(1'b1, 8'h00, 32'h33);
    spot(16'h012c, 16'h0064);
    spot(16'h0096, 16'h000a);
    rdchk(8'h04, 32'h10);
    spot(16'h0096, 16'h0064);
    rdchk(8'h04, 32'h0);
    repeat (3) spot(16'h000a, 16'h0064);
    chk({30'h0, bad_halt, halt}, 32'h3);
    spot(16'h0096, 16'h0064);
    rdchk(8'h08, 32'h6);
    rdchk(8'h04, 32'h19);
    apb(1'b1, 8'h00, 32'h2_0033);
    rdchk(8'h04, 32'h0);
    apb(1'b1, 8'h00, 32'h30);
    repeat (4) spot(16'h012c, 16'h0064);
    rdchk(8'h04, 32'h20);
    chk({31'h0, halt}, 32'h0);
    $display("test bad spots done");
    apb(1'b1, 8'h10, 32'h0000_0003);
    apb(1'b1, 8'h00, 32'h1_0030);
    repeat (3) spot(16'h0096, 16'h0064);
    rdchk(8'h04, 32'h2);
    chk({30'h0, eol, halt}, 32'h3);
    apb(1'b1, 8'h00, 32'h1_0030);
    rdchk(8'h04, 32'h0);
    $display("test spot limit done");
    apb(1'b1, 8'h10, 32'h0032_0004);
    apb(1'b1, 8'h14, 32'h0032_0002);
    apb(1'b1, 8'h00, 32'h1_00b0);
    for (int k = 0; k < 6; k++) begin
      spot(16'h0096, 16'h0064);
      repeat (200) @(posedge pclk);
      rdchk(8'h0c, fac[k]);
      apb(1'b0, 8'h04, 32'h0);
      if (k == 3) chk(rd & 32'h387, 32'h84);
    end
    for (int j = 0; j < 8; j++) chk({16'h0, adj[j]}, {16'h0, sc(base[j])});
    chk({30'h0, eol, halt}, 32'h3);
    apb(1'b1, 8'h00, 32'h1_00b0);
    repeat (200) @(posedge pclk);
    rdchk(8'h0c, {8'h00, ewcs_pkg::UNITY});
    chk({31'h0, eol}, 32'h0);
    apb(1'b1, 8'h10, 32'h0019_0004);
    spot(16'h0096, 16'h0064);
    repeat (200) @(posedge pclk);
    rdchk(8'h0c, 32'h11000);
    $display("test curve done");
    test_done();
  end
endmodule
`default_nettype wire
